// file: verilog/lds_pkg.sv
package lds_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned EN_LOW_US    = 50;
  localparam int unsigned PULSE_MIN_US = 2;
  localparam int unsigned PULSE_MAX_US = 20;
  localparam int unsigned PRE_MS       = 65;
  localparam int unsigned RAMP_MS      = 50;
  localparam int unsigned HOLD_MS      = 100;
  localparam int unsigned EN_LOW_CYC   = EN_LOW_US * CLK_MHZ;
  localparam int unsigned PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
  localparam int unsigned PRE_CYC      = PRE_MS * 1000 * CLK_MHZ;
  localparam int unsigned RAMP_CYC     = RAMP_MS * 1000 * CLK_MHZ;
  localparam int unsigned HOLD_CYC     = HOLD_MS * 1000 * CLK_MHZ;

  localparam int unsigned NUM_STR = 4;
  localparam int unsigned TMR_W   = 25;
  localparam int unsigned ENC_W   = 14;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] LEDFLT_OFS = 12'h008;
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_LEDCLR_BIT  = 1;
  localparam logic        CTRL_RESTART_RST = 1'b1;
  localparam int unsigned ST_LEDLAT_BIT    = 3;
  localparam int unsigned ST_PINLOW_BIT    = 4;
  localparam int unsigned ST_MASK_LSB      = 8;
  localparam int unsigned LF_SHORT_LSB     = 4;
  localparam int unsigned LF_GND_LSB       = 8;

  typedef enum logic [2:0] {
    LDS_IDLE = 3'b000,
    LDS_PRE  = 3'b001,
    LDS_RAMP = 3'b011,
    LDS_NORM = 3'b010,
    LDS_HOLD = 3'b110
  } lds_state_t;

  typedef struct packed {
    logic input_overcurrent;
    logic input_overvoltage;
    logic input_undervoltage;
    logic switch_overvoltage;
    logic thermal_shutdown;
  } lds_flt_t;

endpackage

// file: verilog/lds_sequencer.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - idle entered once input supply good
// RQ2 - idle: enable high wakes regulator, precharge
// RQ3 - enable low over 50 us: back idle
// RQ4 - precharge turns on power-line FET control
// RQ5 - precharge/ramp act only on five supply faults
// RQ6 - precharge lasts 65 ms then ramp
// RQ7 - ramp enables converter, reduced current limit
// RQ8 - after 50 ms ramp, drop grounded strings
// RQ9 - grounded check done: go normal
// RQ10 - normal: enabled sinks conduct while dimming high
// RQ11 - normal acts on all faults incl. LED
// RQ12 - normal after holdoff, no fault: release pin
// RQ13 - non-LED fault enters fault holdoff
// RQ14 - holdoff disables sinks, converter, FET
// RQ15 - holdoff 100 ms then precharge if enabled
// RQ16 - fault output tells host of faults
// RQ17 - holdoff drives fault output low
// RQ18 - 2-20 us enable low pulse clears LED fault
// RQ19 - String_open_fault/short evaluated only in normal
// RQ20 - intervals counted in clock cycles by parameter
module lds_sequencer
  import lds_pkg::*;
#(
  parameter int unsigned P_EN_LOW_CYC = EN_LOW_CYC,
  parameter int unsigned P_PRE_CYC    = PRE_CYC,
  parameter int unsigned P_RAMP_CYC   = RAMP_CYC,
  parameter int unsigned P_HOLD_CYC   = HOLD_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               supply_good_i,
  input  wire logic               supply_enable_pin_i,
  input  wire logic               dim_i,
  input  wire lds_flt_t           supply_flt_i,
  input  wire logic [NUM_STR-1:0] string_open_fault_i,
  input  wire logic [NUM_STR-1:0] string_short_fault_i,
  input  wire logic [NUM_STR-1:0] string_grounded_i,
  output logic                    regulator_en_o,
  output logic                    fet_en_o,
  output logic                    converter_en_o,
  output logic                    reduced_ilim_o,
  output logic [NUM_STR-1:0]      sink_en_o,
  output logic [NUM_STR-1:0]      loop_incl_o,
  output logic                    fault_o,
  output logic                    fault_oe_n_o
);

  localparam logic [ENC_W-1:0] ENL_MAX = ENC_W'(P_EN_LOW_CYC);
  localparam logic [ENC_W-1:0] PMIN    = ENC_W'(PULSE_MIN_CYC);
  localparam logic [ENC_W-1:0] PMAX    = ENC_W'(PULSE_MAX_CYC);
  localparam logic [TMR_W-1:0] PRE_END  = TMR_W'(P_PRE_CYC - 1);
  localparam logic [TMR_W-1:0] RAMP_END = TMR_W'(P_RAMP_CYC - 1);
  localparam logic [TMR_W-1:0] HOLD_END = TMR_W'(P_HOLD_CYC - 1);

  lds_state_t         state_q, state_d;
  logic [TMR_W-1:0]   tmr_q;
  logic [ENC_W-1:0]   enl_q;
  logic [NUM_STR-1:0] mask_q, open_q, short_q, gnd_q;
  logic               led_lat_q, hold_lat_q, restart_q;
  logic               en_gone, supply_bad, led_ev, pulse_clr, sw_clr, wr_ctrl;
  logic [NUM_STR-1:0] led_hit;

  // ----------------------------------------------------------------
  // enable-low qualification
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enl_q <= '0;
    end else if (supply_enable_pin_i) begin
      enl_q <= '0;
    end else if (enl_q != ENL_MAX) begin
      enl_q <= enl_q + 1'b1; // RQ20
    end
  end

  assign en_gone   = !supply_enable_pin_i && (enl_q == ENL_MAX); // RQ3
  // short low pulse ends inside the window
  assign pulse_clr = supply_enable_pin_i && (enl_q >= PMIN) && (enl_q <= PMAX)
                     && (state_q == LDS_NORM); // RQ18
  assign supply_bad = |supply_flt_i; // RQ5 RQ13
  assign led_hit    = (string_open_fault_i | string_short_fault_i) & mask_q;
  assign led_ev     = (state_q == LDS_NORM) && (|led_hit); // RQ19 RQ11

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      LDS_IDLE: begin
        if (supply_good_i && supply_enable_pin_i) begin
          state_d = LDS_PRE; // RQ1 RQ2
        end
      end
      LDS_PRE: begin
        if (en_gone) begin
          state_d = LDS_IDLE; // RQ3
        end else if (supply_bad) begin
          state_d = LDS_HOLD; // RQ5 RQ13
        end else if (tmr_q == PRE_END) begin
          state_d = LDS_RAMP; // RQ6
        end
      end
      LDS_RAMP: begin
        if (en_gone) begin
          state_d = LDS_IDLE; // RQ3
        end else if (supply_bad) begin
          state_d = LDS_HOLD; // RQ5 RQ13
        end else if (tmr_q == RAMP_END) begin
          state_d = LDS_NORM; // RQ9
        end
      end
      LDS_NORM: begin
        if (en_gone) begin
          state_d = LDS_IDLE; // RQ3
        end else if (supply_bad) begin
          state_d = LDS_HOLD; // RQ11 RQ13
        end
      end
      LDS_HOLD: begin
        if (en_gone) begin
          state_d = LDS_IDLE; // RQ3
        end else if (tmr_q >= HOLD_END && supply_enable_pin_i && restart_q) begin
          state_d = LDS_PRE; // RQ15
        end
      end
      default: begin
        state_d = LDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LDS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // interval timer restarts on every state change
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_q <= '0;
    end else if (state_d != state_q) begin
      tmr_q <= '0;
    end else if (tmr_q != HOLD_END) begin
      tmr_q <= tmr_q + 1'b1; // RQ20
    end
  end

  // ----------------------------------------------------------------
  // string mask and LED fault latches
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= '0;
      gnd_q  <= '0;
    end else if (state_q == LDS_RAMP && state_d == LDS_NORM) begin
      mask_q <= ~string_grounded_i; // RQ8
      gnd_q  <= string_grounded_i;
    end else if (state_q == LDS_NORM) begin
      mask_q <= mask_q & ~led_hit; // RQ11
    end else if (state_q != LDS_RAMP) begin
      mask_q <= '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      open_q  <= '0;
      short_q <= '0;
    end else if (state_q == LDS_NORM) begin
      open_q  <= open_q | (string_open_fault_i & mask_q); // RQ19
      short_q <= short_q | (string_short_fault_i & mask_q);
    end else if (state_q == LDS_PRE) begin
      open_q  <= '0;
      short_q <= '0;
    end
  end

  // set beats clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_lat_q <= 1'b0;
    end else if (led_ev) begin
      led_lat_q <= 1'b1; // RQ11
    end else if (pulse_clr || sw_clr || state_q == LDS_IDLE) begin
      led_lat_q <= 1'b0; // RQ18
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_lat_q <= 1'b0;
    end else if (state_d == LDS_HOLD) begin
      hold_lat_q <= 1'b1; // RQ17
    end else if (state_q == LDS_NORM && !supply_bad) begin
      hold_lat_q <= 1'b0; // RQ12
    end else if (state_q == LDS_IDLE) begin
      hold_lat_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_en_o <= 1'b0;
      fet_en_o       <= 1'b0;
      converter_en_o <= 1'b0;
      reduced_ilim_o <= 1'b0;
      sink_en_o      <= '0;
      loop_incl_o    <= '0;
      fault_o        <= 1'b0;
      fault_oe_n_o   <= 1'b1;
    end else begin
      regulator_en_o <= (state_q != LDS_IDLE); // RQ2
      fet_en_o       <= (state_q == LDS_PRE) || (state_q == LDS_RAMP)
                        || (state_q == LDS_NORM); // RQ4 RQ14
      converter_en_o <= (state_q == LDS_RAMP) || (state_q == LDS_NORM); // RQ7 RQ14
      reduced_ilim_o <= (state_q == LDS_RAMP); // RQ7
      sink_en_o      <= (state_q == LDS_NORM && dim_i && supply_enable_pin_i)
                        ? mask_q : '0; // RQ10 RQ14 RQ18
      loop_incl_o    <= (state_q == LDS_NORM) ? mask_q : '0; // RQ8
      fault_o        <= 1'b0;
      fault_oe_n_o   <= !(hold_lat_q || led_lat_q || state_q == LDS_HOLD); // RQ16 RQ17
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  assign wr_ctrl = psel_i && penable_i && pwrite_i && pready_o
                   && (paddr_i == CTRL_OFS);
  assign sw_clr  = wr_ctrl && pwdata_i[CTRL_LEDCLR_BIT] && (state_q == LDS_NORM);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restart_q <= CTRL_RESTART_RST;
    end else if (wr_ctrl) begin
      restart_q <= pwdata_i[CTRL_RESTART_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (psel_i && !penable_i) begin
        if (paddr_i == CTRL_OFS) begin
          prdata_o[CTRL_RESTART_BIT] <= restart_q;
        end else if (paddr_i == STATUS_OFS) begin
          prdata_o[2:0]                <= state_q;
          prdata_o[ST_LEDLAT_BIT]      <= led_lat_q;
          prdata_o[ST_PINLOW_BIT]      <= !fault_oe_n_o;
          prdata_o[ST_MASK_LSB +: NUM_STR] <= mask_q;
        end else if (paddr_i == LEDFLT_OFS) begin
          prdata_o[NUM_STR-1:0]             <= open_q;
          prdata_o[LF_SHORT_LSB +: NUM_STR] <= short_q;
          prdata_o[LF_GND_LSB +: NUM_STR]   <= gnd_q;
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_IDLE_SUPPLY: assert property ( // RQ1
    state_q == LDS_IDLE && !supply_good_i |=> state_q == LDS_IDLE)
    else $error("left idle without supply good");
  AST_WAKE: assert property ( // RQ2
    state_q == LDS_IDLE && supply_good_i && supply_enable_pin_i
    |=> state_q == LDS_PRE ##1 regulator_en_o)
    else $error("enable did not wake device");
  AST_EN_LOW: assert property ( // RQ3
    state_q != LDS_IDLE && !supply_enable_pin_i && enl_q == ENL_MAX
    |=> state_q == LDS_IDLE)
    else $error("long enable low did not reach idle");
  AST_PRE_FET: assert property ( // RQ4
    state_q == LDS_PRE |=> fet_en_o && !converter_en_o)
    else $error("precharge fet control wrong");
  AST_PRE_END: assert property ( // RQ6
    state_q == LDS_PRE && tmr_q == PRE_END && !supply_bad && !en_gone
    |=> state_q == LDS_RAMP)
    else $error("precharge interval not honoured");
  AST_RAMP: assert property ( // RQ7
    state_q == LDS_RAMP |=> converter_en_o && reduced_ilim_o)
    else $error("ramp converter outputs wrong");
  AST_GND: assert property ( // RQ8
    state_q == LDS_RAMP && state_d == LDS_NORM
    |=> state_q == LDS_NORM && mask_q == ~$past(string_grounded_i)
        ##1 loop_incl_o == $past(mask_q))
    else $error("grounded strings not removed");
  AST_DIM: assert property ( // RQ10
    state_q == LDS_NORM && !dim_i |=> sink_en_o == '0)
    else $error("sinks on with dimming low");
  AST_FLT: assert property ( // RQ13
    state_q inside {LDS_PRE, LDS_RAMP, LDS_NORM} && supply_bad && !en_gone
    |=> state_q == LDS_HOLD)
    else $error("supply fault did not enter holdoff");
  AST_HOLD: assert property ( // RQ14
    state_q == LDS_HOLD |=> !fet_en_o && !converter_en_o && sink_en_o == '0
                             && !fault_oe_n_o)
    else $error("holdoff outputs wrong");
  AST_RETRY: assert property ( // RQ15
    state_q == LDS_HOLD && tmr_q < HOLD_END |=> state_q != LDS_PRE)
    else $error("restart before holdoff ends");
  AST_RELEASE: assert property ( // RQ12
    state_q == LDS_NORM && !supply_bad && !led_ev && !led_lat_q
    |=> ##1 fault_oe_n_o)
    else $error("fault output not released");
  AST_PULSE: assert property ( // RQ18
    pulse_clr && !led_ev && !supply_bad |=> !led_lat_q && state_q == LDS_NORM)
    else $error("short pulse did not clear led fault");
  AST_LED_NORM: assert property ( // RQ19
    state_q != LDS_NORM && !led_lat_q |=> !led_lat_q)
    else $error("led fault latched outside normal");

  COV_START: cover property (state_q == LDS_RAMP ##1 state_q == LDS_NORM);
  COV_RECOVER: cover property (state_q == LDS_HOLD ##1 state_q == LDS_PRE);
  COV_PULSE: cover property (led_lat_q && pulse_clr);
  COV_SHUT: cover property (state_q == LDS_NORM ##1 state_q == LDS_IDLE);

endmodule

// file: dv/lds_host_model.sv
`timescale 1ns/1ps
module lds_host_model (
  input  wire logic core_clk_i,
  input  wire logic fault_i,
  input  wire logic fault_oe_n_i,
  output logic      supply_enable_pin_o,
  output logic      dim_o,
  output logic      fault_line_o
);
  // ----------------------------------------------------------------
  // enable, dimming and fault line
  // ----------------------------------------------------------------
  logic       en_q      = 1'b0;
  logic       dim_q     = 1'b0;
  logic       dim_run_q = 1'b0;
  logic [1:0] div_q     = 2'h0;

  assign supply_enable_pin_o = en_q;
  assign dim_o               = dim_q;
  // pull-up on the open-drain line: released reads high
  assign fault_line_o = fault_oe_n_i ? 1'b1 : fault_i;

  always_ff @(posedge core_clk_i) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      dim_q <= dim_run_q & ~dim_q;
    end
  end

  // drives the pin to the given level after one edge and leaves it there
  task automatic set_en(input logic v);
    @(posedge core_clk_i);
    en_q <= v;
  endtask

  // low pulse of n cycles, length not checked against the clearing window
  task automatic low_for(input int n);
    @(posedge core_clk_i);
    en_q <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    en_q <= 1'b1;
  endtask

  task automatic run_dim();
    @(posedge core_clk_i);
    dim_run_q <= 1'b1;
  endtask
endmodule

// file: dv/test_lds_sequencer.sv
`timescale 1ns/1ps
module test_lds_sequencer
  import lds_pkg::*;
;
  localparam int EN_L = 5000;
  localparam int PRE_L = 20;
  localparam int RAMP_L = 20;
  localparam int HOLD_L = 30;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] mask;
    logic        err;
  } lds_row_t;

  logic               core_clk = 1'b0;
  logic               rst_n    = 1'b0;
  logic               psel     = 1'b0;
  logic               penable  = 1'b0;
  logic               pwrite   = 1'b0;
  logic [11:0]        paddr    = 12'h000;
  logic [31:0]        pwdata   = 32'h0;
  logic               good     = 1'b0;
  lds_flt_t           flt      = '0;
  logic [NUM_STR-1:0] opn      = '0;
  logic [NUM_STR-1:0] sht      = '0;
  logic [NUM_STR-1:0] gnd      = '0;
  logic [31:0]        prdata;
  logic               pready, pslverr, reg_en, fet_en, conv_en, ilim, flt_d, flt_oe_n;
  logic [NUM_STR-1:0] sink_en, loop_incl;
  logic               en, dim, fline, pd, er;
  logic [31:0]        rd;
  int                 failures = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  int                 n;
  lds_row_t           rows [8] = '{
    '{1'b0, CTRL_OFS, 32'h0, 32'h1, 32'h3, 1'b0},
    '{1'b1, STATUS_OFS, 32'hffff_ffff, 32'h0, 32'h0, 1'b0},
    '{1'b0, STATUS_OFS, 32'h0, 32'h0, 32'h1f, 1'b0},
    '{1'b0, LEDFLT_OFS, 32'h0, 32'h0, 32'hfff, 1'b0},
    '{1'b1, 12'h00c, 32'h5, 32'h0, 32'h0, 1'b1},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 32'hffff_ffff, 1'b1},
    '{1'b1, CTRL_OFS, 32'h3, 32'h0, 32'h0, 1'b0},
    '{1'b0, CTRL_OFS, 32'h0, 32'h1, 32'h3, 1'b0}};

  lds_sequencer #(.P_EN_LOW_CYC(EN_L), .P_PRE_CYC(PRE_L), .P_RAMP_CYC(RAMP_L),
    .P_HOLD_CYC(HOLD_L)) i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .supply_good_i(good),
    .supply_enable_pin_i(en), .dim_i(dim), .supply_flt_i(flt), .string_open_fault_i(opn),
    .string_short_fault_i(sht), .string_grounded_i(gnd), .regulator_en_o(reg_en),
    .fet_en_o(fet_en), .converter_en_o(conv_en), .reduced_ilim_o(ilim),
    .sink_en_o(sink_en), .loop_incl_o(loop_incl), .fault_o(flt_d), .fault_oe_n_o(flt_oe_n));

  lds_host_model i_host (.core_clk_i(core_clk), .fault_i(flt_d), .fault_oe_n_i(flt_oe_n),
    .supply_enable_pin_o(en), .dim_o(dim), .fault_line_o(fline));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_win(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return fet_en;
      1: return conv_en;
      2: return reg_en;
      default: return ilim;
    endcase
  endfunction

  // counts edges until the selected output is seen at the level
  task automatic wait_sig(input int s, input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (sig(s) !== lvl);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // zero wait states: answer in the first access cycle
    chk("pready_wait", 32'h1, 32'(k));
  endtask

  task automatic pulse_flt(input lds_flt_t f);
    @(posedge core_clk);
    flt <= f;
    @(posedge core_clk);
    flt <= '0;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      chk("pslverr", 32'(rows[i].err), 32'(er));
      chk("prdata", rows[i].rdata & rows[i].mask, rd & rows[i].mask);
    end
    $display("test registers done");
    i_host.set_en(1'b1);
    repeat (10) @(posedge core_clk);
    chk("reg_en", 32'h0, 32'(reg_en));
    good <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk_win("wake", 1, 4, n);
    chk("fet_en", 32'h1, 32'(fet_en));
    opn <= 4'hf;
    gnd <= 4'b0100;
    wait_sig(1, 1'b1, n);
    chk_win("pre_len", PRE_L, PRE_L, n);
    chk("ilim", 32'h1, 32'(ilim));
    chk("fault_line", 32'h1, 32'(fline));
    opn <= '0;
    wait_sig(3, 1'b0, n);
    chk_win("ramp_len", RAMP_L, RAMP_L, n);
    chk("loop_incl", 32'hb, 32'(loop_incl));
    $display("test startup done");
    i_host.run_dim();
    pd = dim;
    repeat (12) begin
      @(posedge core_clk);
      chk("sink_en", pd ? 32'hb : 32'h0, 32'(sink_en));
      pd = dim;
    end
    $display("test dimming done");
    opn <= 4'b0001;
    sht <= 4'b0010;
    repeat (2) @(posedge core_clk);
    opn <= '0;
    sht <= '0;
    repeat (4) @(posedge core_clk);
    chk("loop_incl", 32'h8, 32'(loop_incl));
    chk("fault_line", 32'h0, 32'(fline));
    chk("conv_en", 32'h1, 32'(conv_en));
    fork
      i_host.low_for(1000);
      begin
        repeat (500) @(posedge core_clk);
        chk("sink_en", 32'h0, 32'(sink_en));
      end
    join
    repeat (4) @(posedge core_clk);
    chk("fault_line", 32'h1, 32'(fline));
    chk("conv_en", 32'h1, 32'(conv_en));
    $display("test led fault done");
    apb(1'b1, CTRL_OFS, 32'h0);
    pulse_flt(5'b00001);
    wait_sig(0, 1'b0, n);
    chk_win("hold_entry", 1, 4, n);
    chk("fault_line", 32'h0, 32'(fline));
    chk("conv_en", 32'h0, 32'(conv_en));
    chk("sink_en", 32'h0, 32'(sink_en));
    repeat (HOLD_L + 10) @(posedge core_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("state", 32'h6, rd & 32'h7);
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_sig(0, 1'b1, n);
    pulse_flt(5'b10000);
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    chk_win("hold_len", HOLD_L, HOLD_L, n);
    wait_sig(3, 1'b1, n);
    wait_sig(3, 1'b0, n);
    repeat (3) @(posedge core_clk);
    chk("fault_line", 32'h1, 32'(fline));
    $display("test holdoff done");
    opn <= 4'b1000;
    @(posedge core_clk);
    opn <= '0;
    repeat (3) @(posedge core_clk);
    chk("fault_line", 32'h0, 32'(fline));
    apb(1'b1, CTRL_OFS, 32'h3);
    repeat (3) @(posedge core_clk);
    chk("fault_line", 32'h1, 32'(fline));
    $display("test software clear done");
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("fault_line", 32'h1, 32'(fline));
    chk("fet_en", 32'h0, 32'(fet_en));
    chk("reg_en", 32'h0, 32'(reg_en));
    rst_n <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk_win("rst_wake", 1, 4, n);
    $display("test reset done");
    i_host.set_en(1'b0);
    wait_sig(2, 1'b0, n);
    chk_win("en_low", EN_L, EN_L + 4, n);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("state", 32'h0, rd & 32'h7);
    $display("test shutdown done");
    end_sim();
  end
endmodule
